// ### hdl/boot_mag_pkg.sv
package boot_mag_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] die_temperature_addr = 8'h01;
   localparam logic [7:0] magnitude_low_byte_addr = 8'h02;
   localparam logic [7:0] magnitude_high_byte_addr = 8'h03;
   localparam logic [7:0] mag_reset = 8'h00;
   localparam logic [7:0] temp_reset = 8'h00;
   localparam logic [7:0] unmapped_read = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int clock_mhz = 40;
   localparam int short_boot_pulse_time_us = 10;
   localparam int long_boot_pulse_time_ms = 1;
   localparam int short_boot_cycles = short_boot_pulse_time_us * clock_mhz;
   localparam int long_boot_cycles = long_boot_pulse_time_ms * 1000 * clock_mhz;
   localparam int pulse_count_width = 20;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      st_booting = 4'b0001,
      st_pulse = 4'b0010,
      st_ready = 4'b0100,
      st_spare = 4'b1000
   } boot_state_t;

   typedef struct packed {
      logic irq_polarity;
      logic irq_drive_type;
      logic boot_route_to_second_line;
      logic boot_irq_enable;
      logic byte_order_select;
      logic magnitude_calc_enable;
   } pin_setup_t;

   typedef struct packed {
      logic valid;
      logic [7:0] temperature;
      logic [11:0] magnitude;
   } sample_t;

   typedef struct packed {
      logic read;
      logic [7:0] addr;
   } bus_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic ok;
      logic fail;
   } bus_rsp_t;

endpackage : boot_mag_pkg

// ### hdl/pulse_timer.sv
`timescale 1ns/100ps
module pulse_timer
   import boot_mag_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [pulse_count_width-1:0] length,
   output logic busy
);

   typedef struct packed {
      logic busy;
      logic [pulse_count_width-1:0] count;
   } timer_state_t;

   timer_state_t cur;
   timer_state_t next_cur;

   always_comb begin
      next_cur = cur;
      if (start) begin
         next_cur.busy = 1'b1;
         next_cur.count = length;
      end else if (cur.busy) begin
         if (cur.count <= pulse_count_width'(1)) begin
            next_cur.busy = 1'b0;
            next_cur.count = '0;
         end else begin
            next_cur.count = cur.count - pulse_count_width'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign busy = cur.busy;

endmodule : pulse_timer

// ### hdl/boot_flag_temp_magnitude_regs.sv
`timescale 1ns/100ps
module boot_flag_temp_magnitude_regs
   import boot_mag_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic soft_reset,
   input wire logic hibernate_exit,
   input wire logic boot_sequence_done,
   input wire logic boot_strap_select,
   input wire logic setup_write,
   input wire pin_setup_t setup_in,
   input wire sample_t sample_in,
   input wire bus_req_t bus_in,
   input wire logic bus_write,
   output logic boot_done_flag,
   output logic sample_ready_flag,
   output logic irq_line_one,
   output logic irq_line_one_oe_n,
   output logic irq_line_two_boot_output,
   output logic irq_line_two_boot_output_oe_n,
   output bus_rsp_t bus_out,
   output logic [7:0] die_temperature,
   output logic [7:0] magnitude_low_byte,
   output logic [7:0] magnitude_high_byte
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      boot_state_t state;
      logic strap;
      logic boot_done_flag;
      logic sample_ready_flag;
      pin_setup_t setup;
      logic [7:0] temperature;
      logic [11:0] magnitude;
      logic pulse_long;
      logic irq_one;
      logic irq_one_oe_n;
      logic irq_two;
      logic irq_two_oe_n;
      bus_rsp_t rsp;
      logic [7:0] mag_low;
      logic [7:0] mag_high;
   } regs_state_t;

   regs_state_t cur;
   regs_state_t next_cur;
   logic timer_start;
   logic timer_busy;
   logic [pulse_count_width-1:0] timer_length;
   logic boot_reset;
   logic active_level;
   logic on_two;

   assign boot_reset = soft_reset | hibernate_exit;

   pulse_timer boot_timer (
      .clock(clock),
      .rst_n(rst_n),
      .start(timer_start),
      .length(timer_length),
      .busy(timer_busy)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      timer_start = 1'b0;
      timer_length = pulse_count_width'(short_boot_cycles);
      next_cur.rsp.ok = 1'b0;
      next_cur.rsp.fail = 1'b0;
      next_cur.rsp.data = cur.rsp.data;

      // Boot sequencing
      case (cur.state)
         st_booting: begin
            next_cur.strap = boot_strap_select;
            if (boot_sequence_done) begin
               next_cur.boot_done_flag = 1'b1;
               if (boot_strap_select) begin
                  timer_length = pulse_count_width'(long_boot_cycles);
                  timer_start = 1'b1;
                  next_cur.pulse_long = 1'b1;
                  next_cur.state = st_pulse;
               end else if (cur.setup.boot_irq_enable) begin
                  timer_start = 1'b1;
                  next_cur.pulse_long = 1'b0;
                  next_cur.state = st_pulse;
               end else begin
                  next_cur.state = st_ready;
               end
            end
         end
         st_pulse: begin
            if (!timer_busy) begin
               next_cur.state = st_ready;
            end
         end
         st_ready: begin
            next_cur.state = st_ready;
         end
         default: begin
            next_cur.state = st_booting;
         end
      endcase

      // Pin drive: active only while the pulse timer runs
      active_level = !cur.setup.irq_polarity;
      on_two = cur.setup.boot_route_to_second_line;
      next_cur.irq_one = cur.setup.irq_polarity;
      next_cur.irq_two = cur.setup.irq_polarity;
      next_cur.irq_one_oe_n = cur.setup.irq_drive_type;
      next_cur.irq_two_oe_n = cur.setup.irq_drive_type;
      if (cur.state == st_pulse && timer_busy) begin
         if (cur.pulse_long) begin
            next_cur.irq_two = 1'b0;
            next_cur.irq_two_oe_n = 1'b0;
         end else if (on_two) begin
            next_cur.irq_two = active_level;
            next_cur.irq_two_oe_n = cur.setup.irq_drive_type & !active_level;
         end else begin
            next_cur.irq_one = active_level;
            next_cur.irq_one_oe_n = cur.setup.irq_drive_type & !active_level;
         end
      end
      if (cur.pulse_long && cur.state == st_pulse) begin
         next_cur.irq_one_oe_n = 1'b1;
      end else if (cur.state != st_pulse || cur.pulse_long) begin
         next_cur.irq_one_oe_n = next_cur.irq_one_oe_n;
      end
      // Open-drain idle level releases the pin
      if (cur.setup.irq_drive_type && next_cur.irq_one != active_level) begin
         next_cur.irq_one_oe_n = 1'b1;
      end
      if ((cur.setup.irq_drive_type || cur.pulse_long) && cur.state == st_pulse
          && next_cur.irq_two_oe_n) begin
         next_cur.irq_two_oe_n = 1'b1;
      end

      // Setup writes only once booted
      if (setup_write && cur.boot_done_flag) begin
         next_cur.setup = setup_in;
      end

      // Sample latch: temperature always, magnitude only when magnitude_calc_enable is set
      if (sample_in.valid) begin
         next_cur.temperature = sample_in.temperature;
         if (cur.setup.magnitude_calc_enable) begin
            next_cur.magnitude = sample_in.magnitude;
         end
      end

      // Bus access
      if ((bus_in.read || bus_write) && !cur.boot_done_flag) begin
         next_cur.rsp.fail = 1'b1;
      end else if (bus_in.read) begin
         next_cur.rsp.ok = 1'b1;
         if (bus_in.addr == die_temperature_addr) begin
            next_cur.rsp.data = cur.temperature;
         end else if (bus_in.addr == magnitude_low_byte_addr) begin
            next_cur.rsp.data = cur.mag_low;
         end else if (bus_in.addr == magnitude_high_byte_addr) begin
            next_cur.rsp.data = cur.mag_high;
         end else begin
            next_cur.rsp.data = unmapped_read;
         end
      end else if (bus_write) begin
         next_cur.rsp.ok = 1'b1;
      end

      // Sample-ready: set wins over read clear
      if (sample_in.valid) begin
         next_cur.sample_ready_flag = 1'b1;
      end else if (bus_in.read && cur.boot_done_flag
                   && (bus_in.addr == magnitude_low_byte_addr
                       || bus_in.addr == magnitude_high_byte_addr)) begin
         next_cur.sample_ready_flag = 1'b0;
      end

      // Byte order of the magnitude view
      if (next_cur.setup.byte_order_select) begin
         next_cur.mag_low = next_cur.magnitude[11:4];
         next_cur.mag_high = {next_cur.magnitude[3:0], 4'h0};
      end else begin
         next_cur.mag_low = next_cur.magnitude[7:0];
         next_cur.mag_high = {4'h0, next_cur.magnitude[11:8]};
      end

      // Soft reset or hibernate exit restarts boot, keeps pin settings; hibernate exit clears irq_polarity
      if (boot_reset) begin
         next_cur.state = st_booting;
         next_cur.boot_done_flag = 1'b0;
         next_cur.sample_ready_flag = 1'b0;
         next_cur.pulse_long = 1'b0;
         next_cur.rsp = '0;
         next_cur.setup.irq_polarity = cur.setup.irq_polarity;
         next_cur.setup.irq_drive_type = cur.setup.irq_drive_type;
         next_cur.setup.boot_route_to_second_line = cur.setup.boot_route_to_second_line;
         if (hibernate_exit) begin
            next_cur.setup.irq_polarity = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{state: st_booting, strap: 1'b0, boot_done_flag: 1'b0,
                  sample_ready_flag: 1'b0,
                  setup: '{irq_polarity: 1'b0, irq_drive_type: 1'b0,
                           boot_route_to_second_line: 1'b0, boot_irq_enable: 1'b1,
                           byte_order_select: 1'b0, magnitude_calc_enable: 1'b0},
                  temperature: temp_reset, magnitude: 12'h000, pulse_long: 1'b0,
                  irq_one: 1'b0, irq_one_oe_n: 1'b0, irq_two: 1'b0, irq_two_oe_n: 1'b0,
                  rsp: '0, mag_low: mag_reset, mag_high: mag_reset};
      end else begin
         cur <= next_cur;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign boot_done_flag = cur.boot_done_flag;
   assign sample_ready_flag = cur.sample_ready_flag;
   assign irq_line_one = cur.irq_one;
   assign irq_line_one_oe_n = cur.irq_one_oe_n;
   assign irq_line_two_boot_output = cur.irq_two;
   assign irq_line_two_boot_output_oe_n = cur.irq_two_oe_n;
   assign bus_out = cur.rsp;
   assign die_temperature = cur.temperature;
   assign magnitude_low_byte = cur.mag_low;
   assign magnitude_high_byte = cur.mag_high;

endmodule : boot_flag_temp_magnitude_regs

// ### tb/board_pins.sv
`timescale 1ns/100ps
// ------------------------------
// Open-drain line with pull-up
// ------------------------------
module board_pins (
   input wire logic drive,
   input wire logic drive_oe_n,
   output logic level
);
   assign level = drive_oe_n ? 1'b1 : drive;
endmodule : board_pins

// ### tb/boot_mag_asserts.sv
`timescale 1ns/100ps
module boot_mag_checker
   import boot_mag_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic soft_reset,
   input wire logic hibernate_exit,
   input wire logic boot_sequence_done,
   input wire logic boot_strap_select,
   input wire sample_t sample_in,
   input wire bus_req_t bus_in,
   input wire logic bus_write,
   input wire logic boot_done_flag,
   input wire logic sample_ready_flag,
   input wire logic irq_line_two_boot_output,
   input wire logic irq_line_two_boot_output_oe_n,
   input wire bus_rsp_t bus_out,
   input wire logic [7:0] die_temperature,
   input wire logic [7:0] magnitude_high_byte
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic acc;
   logic calm;
   assign acc = bus_in.read | bus_write;
   assign calm = !soft_reset && !hibernate_exit;
   sequence s_od_low;
      (!irq_line_two_boot_output && !irq_line_two_boot_output_oe_n) [*8];
   endsequence
   property p_fail_early;
      acc && !boot_done_flag && calm |=> bus_out.fail && !bus_out.ok;
   endproperty
   a_fail_early: assert property (p_fail_early) else $error("early access");
   property p_ok_late;
      acc && boot_done_flag && calm |=> bus_out.ok && !bus_out.fail;
   endproperty
   a_ok_late: assert property (p_ok_late) else $error("access refused");
   property p_boot_set;
      !boot_done_flag && boot_sequence_done && calm |=> boot_done_flag;
   endproperty
   a_boot_set: assert property (p_boot_set) else $error("boot flag not set");
   property p_boot_hold;
      boot_done_flag && calm |=> boot_done_flag;
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("boot flag lost");
   property p_latch;
      sample_in.valid && calm |=> sample_ready_flag
         && die_temperature == $past(sample_in.temperature);
   endproperty
   a_latch: assert property (p_latch) else $error("sample not latched");
   property p_rd_clear;
      bus_in.read && bus_in.addr == magnitude_low_byte_addr && boot_done_flag
         && !sample_in.valid |=> !sample_ready_flag;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("ready not cleared");
   property p_nibble;
      magnitude_high_byte[7:4] == 4'h0 || magnitude_high_byte[3:0] == 4'h0;
   endproperty
   a_nibble: assert property (p_nibble) else $error("high byte layout");
   property p_strap_pulse;
      boot_strap_select && $rose(boot_done_flag) |=> s_od_low;
   endproperty
   a_strap_pulse: assert property (p_strap_pulse) else $error("no boot pulse");
endmodule : boot_mag_checker
bind boot_flag_temp_magnitude_regs boot_mag_checker u_chk (.clock, .rst_n, .soft_reset,
   .hibernate_exit, .boot_sequence_done, .boot_strap_select, .sample_in, .bus_in,
   .bus_write, .boot_done_flag, .sample_ready_flag, .irq_line_two_boot_output,
   .irq_line_two_boot_output_oe_n, .bus_out, .die_temperature, .magnitude_high_byte);

// ### tb/tb.sv
`timescale 1ns/100ps
module tb
   import boot_mag_pkg::*;
;
   logic clock = 0, rst_n = 0, soft_reset = 0, hibernate_exit = 0, boot_sequence_done = 0;
   logic boot_strap_select = 0, setup_write = 0, bus_write = 0;
   pin_setup_t setup_in = '0;
   sample_t sample_in = '0;
   bus_req_t bus_in = '0;
   bus_rsp_t bus_out;
   logic boot_done_flag, sample_ready_flag, irq_line_one, irq_line_one_oe_n;
   logic irq_line_two_boot_output, irq_line_two_boot_output_oe_n, line_two;
   logic [7:0] die_temperature, magnitude_low_byte, magnitude_high_byte;
   int fails = 0, compares = 0;
   boot_flag_temp_magnitude_regs dut (.clock(clock), .rst_n(rst_n), .soft_reset(soft_reset),
      .hibernate_exit(hibernate_exit), .boot_sequence_done(boot_sequence_done),
      .boot_strap_select(boot_strap_select), .setup_write(setup_write), .setup_in(setup_in),
      .sample_in(sample_in), .bus_in(bus_in), .bus_write(bus_write),
      .boot_done_flag(boot_done_flag), .sample_ready_flag(sample_ready_flag),
      .irq_line_one(irq_line_one), .irq_line_one_oe_n(irq_line_one_oe_n),
      .irq_line_two_boot_output(irq_line_two_boot_output),
      .irq_line_two_boot_output_oe_n(irq_line_two_boot_output_oe_n), .bus_out(bus_out),
      .die_temperature(die_temperature), .magnitude_low_byte(magnitude_low_byte),
      .magnitude_high_byte(magnitude_high_byte));
   board_pins u_pins (.drive(irq_line_two_boot_output),
      .drive_oe_n(irq_line_two_boot_output_oe_n), .level(line_two));
   initial begin
      forever #12.5 clock = ~clock;
   end
   // ------------------------------
   // Result, check and access tasks
   // ------------------------------
   task complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task acc(input logic rd, input logic [7:0] a, input logic okx, input logic [7:0] e);
      @(posedge clock);
      bus_in <= '{rd, a};
      bus_write <= !rd;
      @(posedge clock);
      bus_in <= '0;
      bus_write <= 0;
      #1 chk("ok", okx, bus_out.ok);
      chk("fail", !okx, bus_out.fail);
      if (okx && rd) chk("data", e, bus_out.data);
   endtask : acc
   task pulse(input int k);
      @(posedge clock);
      case (k)
         0: boot_sequence_done <= 1;
         1: soft_reset <= 1;
         2: hibernate_exit <= 1;
         default: setup_write <= 1;
      endcase
      @(posedge clock);
      {boot_sequence_done, soft_reset, hibernate_exit, setup_write} <= '0;
      #1;
   endtask : pulse
   task smp(input logic [7:0] t, input logic [11:0] m);
      @(posedge clock);
      sample_in <= '{1'b1, t, m};
      @(posedge clock);
      sample_in <= '0;
      #1 chk("temp", t, die_temperature);
      chk("ready", 1, sample_ready_flag);
   endtask : smp
   task setw(input pin_setup_t s);
      setup_in <= s;
      pulse(3);
   endtask : setw
   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1;
      acc(1, magnitude_low_byte_addr, 0, 0);
      pulse(0);
      chk("boot", 1, boot_done_flag);
      repeat (3) @(posedge clock);
      #1 chk("line1", 1, irq_line_one);
      chk("line1 oe", 0, irq_line_one_oe_n);
      repeat (450) @(posedge clock);
      #1 chk("line1 end", 0, irq_line_one);
      smp(8'h85, 12'habc);
      chk("mag off", mag_reset, magnitude_low_byte);
      setw(6'b000101);
      smp(8'h7f, 12'habc);
      acc(1, magnitude_high_byte_addr, 1, 8'h0a);
      chk("ready clr", 0, sample_ready_flag);
      acc(1, magnitude_low_byte_addr, 1, 8'hbc);
      acc(0, die_temperature_addr, 1, 0);
      acc(1, die_temperature_addr, 1, 8'h7f);
      setw(6'b000111);
      smp(8'h00, 12'habc);
      chk("mag high", 8'hc0, magnitude_high_byte);
      acc(1, magnitude_low_byte_addr, 1, 8'hab);
      acc(1, magnitude_high_byte_addr, 1, 8'hc0);
      setw(6'b101101);
      pulse(1);
      chk("boot sr", 0, boot_done_flag);
      acc(1, magnitude_low_byte_addr, 0, 0);
      pulse(0);
      repeat (3) @(posedge clock);
      #1 chk("line2 sr", 0, irq_line_two_boot_output);
      chk("line2 oe", 0, irq_line_two_boot_output_oe_n);
      repeat (450) @(posedge clock);
      boot_strap_select <= 1;
      #1 chk("line2 idle", 1, irq_line_two_boot_output);
      pulse(2);
      chk("boot hx", 0, boot_done_flag);
      pulse(0);
      repeat (3) @(posedge clock);
      #1 chk("line2 od", 0, line_two);
      chk("line2 od oe", 0, irq_line_two_boot_output_oe_n);
      complete_run();
   end
   initial begin
      #(25 * 20000);
      fails++;
      complete_run();
   end
endmodule : tb
